// File: core/cspwm_defs.svh
`ifndef CSPWM_DEFS_SVH
`define CSPWM_DEFS_SVH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define CSPWM_CHANNELS 4
`define CSPWM_GRAY_W 10
`define CSPWM_BRIGHT_W 12
`define CSPWM_FRAME_BITS 52
`define CSPWM_BRIGHT_LSB 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CSPWM_CLK_NS 50
`define CSPWM_MIN_PULSE_NS 80
`define CSPWM_MIN_PULSE_CYC ((`CSPWM_MIN_PULSE_NS + `CSPWM_CLK_NS - 1) / `CSPWM_CLK_NS)
`define CSPWM_LATCH_GAP_NS 10000
`define CSPWM_LATCH_GAP_CYC ((`CSPWM_LATCH_GAP_NS + `CSPWM_CLK_NS - 1) / `CSPWM_CLK_NS)
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSPWM_SR_RST 52'h0
`define CSPWM_SEL_COMMON 4'h1
`define CSPWM_SEL_SPLIT 4'hf
`endif

// File: core/cspwm_pkg.sv
package cspwm_pkg;
  typedef enum logic {
    CSPWM_RUN = 1'b0,
    CSPWM_HOT = 1'b1
  } cspwm_therm_t;
endpackage

// File: core/cspwm_top.sv
`timescale 1ns/10ps
`include "cspwm_defs.svh"

// Overview of operation
// - Serial input bit shifts into the shift register on each link clock rise.
// - Shifted bits leave on the serial output a full frame of link clock rises later.
// - Clock output is the inverse of the received link clock.
// - Link between parties is only a clock line and a data line.
// - Each of four sinks is modulated by its own 10-bit grayscale value.
// - A 12-bit global brightness scales every grayscale duty.
// - Shortest nonzero on-pulse is stretched to at least 80 ns.
// - PWM counter advances only on received link clock rises.
// - Received frame moves to output latches without any strobe signal.
// - After power-on all sinks stay off until a frame is latched.
// - Sinks stop above 160 C and restart only below 110 C.
// - Select low routes all outputs to resistor pin zero, high to own pins.
module cspwm_top #(
  parameter int FRAME_BITS = `CSPWM_FRAME_BITS,
  parameter int GAP_CYC = `CSPWM_LATCH_GAP_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic link_clock_in,
  input wire logic serial_in_line,
  input wire logic current_select,
  input wire logic temp_above_high,
  input wire logic temp_below_low,
  output logic serial_out_line,
  output logic inverted_clock_out,
  output logic [3:0] current_resistor_pins_en,
  output logic [3:0] sink_on
);
  localparam int NCH = `CSPWM_CHANNELS;
  localparam int GW = `CSPWM_GRAY_W;
  localparam int BW = `CSPWM_BRIGHT_W;
  localparam int MINP = `CSPWM_MIN_PULSE_CYC;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ck_m_r, ck_s_r, ck_d_r;
  logic data_m_r, data_s_r;
  logic sel_m_r, sel_s_r;
  logic hi_m_r, hi_s_r, lo_m_r, lo_s_r;
  logic ck_rise, ck_edge;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ck_m_r <= 1'b0;
      ck_s_r <= 1'b0;
      ck_d_r <= 1'b0;
      data_m_r <= 1'b0;
      data_s_r <= 1'b0;
      sel_m_r <= 1'b0;
      sel_s_r <= 1'b0;
      hi_m_r <= 1'b0;
      hi_s_r <= 1'b0;
      lo_m_r <= 1'b0;
      lo_s_r <= 1'b0;
    end else if (clk_en) begin
      ck_m_r <= link_clock_in;
      ck_s_r <= ck_m_r;
      ck_d_r <= ck_s_r;
      data_m_r <= serial_in_line;
      data_s_r <= data_m_r;
      sel_m_r <= current_select;
      sel_s_r <= sel_m_r;
      hi_m_r <= temp_above_high;
      hi_s_r <= hi_m_r;
      lo_m_r <= temp_below_low;
      lo_s_r <= lo_m_r;
    end
  end

  assign ck_rise = clk_en && ck_s_r && !ck_d_r;
  assign ck_edge = clk_en && (ck_s_r != ck_d_r);

  // ----------------------------------------
  // Shift register and cascade output
  // ----------------------------------------
  logic [FRAME_BITS-1:0] sr_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sr_r <= '0;
      serial_out_line <= 1'b0;
    end else if (ck_rise) begin
      sr_r <= {sr_r[FRAME_BITS-2:0], data_s_r};
      serial_out_line <= sr_r[FRAME_BITS-1];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inverted_clock_out <= 1'b1;
    end else if (clk_en) begin
      inverted_clock_out <= !ck_s_r;
    end
  end

  // ----------------------------------------
  // Automatic latch on idle gap
  // ----------------------------------------
  logic [15:0] gap_r;
  logic [7:0] bits_r;
  logic frame_full, latch_go, valid_r;
  logic [GW-1:0] gray_r [NCH];
  logic [BW-1:0] bright_r;

  assign frame_full = (bits_r == 8'(FRAME_BITS));
  assign latch_go = clk_en && !ck_edge && frame_full && (gap_r == 16'(GAP_CYC - 1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap_r <= '0;
    end else if (clk_en) begin
      if (ck_edge) begin
        gap_r <= '0;
      end else if (gap_r != 16'hffff) begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bits_r <= '0;
    end else if (latch_go) begin
      bits_r <= '0;
    end else if (ck_rise && !frame_full) begin
      bits_r <= bits_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      valid_r <= 1'b0;
      bright_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        gray_r[i] <= '0;
      end
    end else if (latch_go) begin
      valid_r <= 1'b1;
      bright_r <= sr_r[`CSPWM_BRIGHT_LSB +: BW];
      for (int i = 0; i < NCH; i++) begin
        gray_r[i] <= sr_r[FRAME_BITS-1-GW*i -: GW];
      end
    end
  end

  // ----------------------------------------
  // Thermal shutdown with hysteresis
  // ----------------------------------------
  cspwm_pkg::cspwm_therm_t therm_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      therm_r <= cspwm_pkg::CSPWM_RUN;
    end else if (clk_en) begin
      unique case (therm_r)
        cspwm_pkg::CSPWM_RUN: begin
          if (hi_s_r) begin
            therm_r <= cspwm_pkg::CSPWM_HOT;
          end
        end
        cspwm_pkg::CSPWM_HOT: begin
          if (lo_s_r && !hi_s_r) begin
            therm_r <= cspwm_pkg::CSPWM_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Current reference select
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      current_resistor_pins_en <= `CSPWM_SEL_COMMON;
    end else if (clk_en) begin
      current_resistor_pins_en <= sel_s_r ? `CSPWM_SEL_SPLIT : `CSPWM_SEL_COMMON;
    end
  end

  // ----------------------------------------
  // PWM duty generation
  // ----------------------------------------
  logic [GW-1:0] pwm_cnt_r;
  logic [GW-1:0] duty [NCH];
  logic [NCH-1:0] pwm_on_r;
  logic [1:0] hold_r [NCH];
  logic outs_ok;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt_r <= '0;
    end else if (ck_rise) begin
      pwm_cnt_r <= pwm_cnt_r + 10'h001;
    end
  end

  always_comb begin
    logic [GW+BW:0] prod;
    prod = '0;
    for (int i = 0; i < NCH; i++) begin
      prod = gray_r[i] * ({1'b0, bright_r} + 13'h0001);
      duty[i] = prod[BW +: GW];
      if (gray_r[i] != '0 && duty[i] == '0) begin
        duty[i] = 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwm_on_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        hold_r[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (pwm_cnt_r < duty[i]) begin
          pwm_on_r[i] <= 1'b1;
          if (!pwm_on_r[i]) begin
            hold_r[i] <= 2'(MINP - 1);
          end
        end else if (hold_r[i] != '0) begin
          hold_r[i] <= hold_r[i] - 2'h1;
        end else begin
          pwm_on_r[i] <= 1'b0;
        end
      end
    end
  end

  assign outs_ok = valid_r && (therm_r == cspwm_pkg::CSPWM_RUN);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sink_on <= '0;
    end else if (clk_en) begin
      sink_on <= outs_ok ? pwm_on_r : 4'h0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_shift_in;
    @(posedge clk_sys) disable iff (!nrst)
      ck_rise |=> (sr_r[0] == $past(data_s_r));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("Input bit not shifted");

  property p_forward;
    @(posedge clk_sys) disable iff (!nrst)
      ck_rise |=> (serial_out_line == $past(sr_r[FRAME_BITS-1]));
  endproperty
  a_forward: assert property (p_forward) else $error("Serial output wrong");

  property p_inv_clk;
    @(posedge clk_sys) disable iff (!nrst)
      clk_en |=> (inverted_clock_out == !$past(ck_s_r));
  endproperty
  a_inv_clk: assert property (p_inv_clk) else $error("Clock output not inverted");

  property p_pwm_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !ck_rise |=> $stable(pwm_cnt_r);
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) else $error("PWM moved without link edge");

  property p_duty_scale;
    @(posedge clk_sys) disable iff (!nrst)
      duty[0] <= gray_r[0];
  endproperty
  a_duty_scale: assert property (p_duty_scale) else $error("Duty above grayscale");

  property p_min_pulse;
    @(posedge clk_sys) disable iff (!nrst)
      ($rose(pwm_on_r[0]) && clk_en) |-> pwm_on_r[0] [*2];
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("On pulse too short");

  property p_zero_off;
    @(posedge clk_sys) disable iff (!nrst)
      (gray_r[1] == '0 && hold_r[1] == '0 && clk_en) |=> !pwm_on_r[1];
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("Zero grayscale drives sink");

  property p_latch;
    @(posedge clk_sys) disable iff (!nrst)
      latch_go |=> (valid_r && bits_r == '0 && gray_r[0] == $past(sr_r[FRAME_BITS-1 -: GW]));
  endproperty
  a_latch: assert property (p_latch) else $error("Frame not latched");

  property p_por;
    @(posedge clk_sys) disable iff (!nrst)
      !valid_r |-> (sink_on == 4'h0);
  endproperty
  a_por: assert property (p_por) else $error("Sink on before first latch");

  property p_hot_off;
    @(posedge clk_sys) disable iff (!nrst)
      (therm_r == cspwm_pkg::CSPWM_HOT && clk_en) |=> (sink_on == 4'h0);
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("Sink on while hot");

  property p_hyst;
    @(posedge clk_sys) disable iff (!nrst)
      (therm_r == cspwm_pkg::CSPWM_HOT && !lo_s_r) |=> (therm_r == cspwm_pkg::CSPWM_HOT);
  endproperty
  a_hyst: assert property (p_hyst) else $error("Restarted before cooling");

  property p_sel;
    @(posedge clk_sys) disable iff (!nrst)
      (clk_en && !sel_s_r) |=> (current_resistor_pins_en == 4'h1);
  endproperty
  a_sel: assert property (p_sel) else $error("Common reference not chosen");

endmodule

// File: tb/cspwm_up_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Upstream link driver
// ----------------------------------------
module cspwm_up_model (
  input wire logic clk_sys,
  output logic link_clock_in,
  output logic serial_in_line
);
  initial begin
    link_clock_in = 1'b0;
    serial_in_line = 1'b0;
  end
  // Clock and data wires only, 400 ns period
  task automatic send_bit(input logic b);
    serial_in_line <= b;
    repeat (2) @(posedge clk_sys);
    link_clock_in <= 1'b1; // Data stable around rise
    repeat (4) @(posedge clk_sys);
    link_clock_in <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic send_frame(input logic [51:0] f);
    for (int i = 51; i >= 0; i--) begin
      send_bit(f[i]);
    end
    serial_in_line <= ~f[0];
  endtask
endmodule

// File: tb/test_cascaded_serial_pwm_led_driver.sv
`timescale 1ns/10ps
module test_cascaded_serial_pwm_led_driver;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic current_select = 1'b0;
  logic temp_above_high = 1'b0;
  logic temp_below_low = 1'b0;
  logic counting = 1'b0;
  logic clk_en = 1'b1;
  logic link_clock_in, serial_in_line, serial_out_line, inverted_clock_out;
  logic [3:0] current_resistor_pins_en, sink_on;
  logic [51:0] frame_a = {10'h3ff, 10'h000, 10'h200, 10'h001, 12'h7ff};
  int on_cnt [4] = '{0, 0, 0, 0};
  int failures = 0;
  int num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  cspwm_top #(.FRAME_BITS(52), .GAP_CYC(20)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .link_clock_in(link_clock_in),
    .serial_in_line(serial_in_line), .current_select(current_select),
    .temp_above_high(temp_above_high), .temp_below_low(temp_below_low),
    .serial_out_line(serial_out_line), .inverted_clock_out(inverted_clock_out),
    .current_resistor_pins_en(current_resistor_pins_en), .sink_on(sink_on));
  cspwm_up_model up_u (.clk_sys(clk_sys), .link_clock_in(link_clock_in),
    .serial_in_line(serial_in_line));
  always @(posedge clk_sys) begin
    if (counting) begin
      for (int i = 0; i < 4; i++) begin
        on_cnt[i] += (sink_on[i] === 1'b1) ? 1 : 0;
      end
    end
  end
  // ----------------------------------------
  // Compare and wait helpers
  // ----------------------------------------
  task automatic check4(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wait_sink(input logic [3:0] mask, input logic [3:0] exp);
    int n;
    n = 0;
    while ((sink_on & mask) !== exp && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 300) begin
      failures++;
      $display("BAD sink wait expected %h seen %h", exp, sink_on & mask);
      give_verdict();
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check4("sink_on", 4'h0, sink_on);
    check4("outs", 4'h1, {2'b00, serial_out_line, inverted_clock_out});
    $display("test reset done");
  endtask
  task automatic test_select();
    current_select <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check4("pins_en", 4'hf, current_resistor_pins_en);
    current_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check4("pins_en", 4'h1, current_resistor_pins_en);
    $display("test select done");
  endtask
  task automatic test_latch();
    for (int i = 0; i < 51; i++) begin
      up_u.send_bit(1'b1);
    end
    repeat (60) @(posedge clk_sys);
    check4("short frame", 4'h0, sink_on);
    up_u.send_frame(frame_a);
    wait_sink(4'h1, 4'h1);
    check4("zero gray", 4'h0, sink_on & 4'h2);
    $display("test latch done");
  endtask
  task automatic test_thermal();
    temp_above_high <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check4("hot", 4'h0, sink_on);
    temp_above_high <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check4("between", 4'h0, sink_on);
    temp_below_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    temp_below_low <= 1'b0;
    check4("cool", 4'h1, sink_on & 4'h1);
    $display("test thermal done");
  endtask
  task automatic test_forward_pwm();
    counting <= 1'b1;
    for (int i = 1023; i >= 0; i--) begin
      up_u.send_bit(1'b0);
      if (i >= 972) begin
        check4("data out", {3'h0, frame_a[i - 972]}, {3'h0, serial_out_line});
        check4("clk out", 4'h0, {3'h0, inverted_clock_out});
      end
    end
    counting <= 1'b0;
    @(posedge clk_sys);
    check_rng("ch0 on", 4072, 4104, on_cnt[0]);
    check_rng("ch1 on", 0, 0, on_cnt[1]);
    check_rng("ch2 on", 2032, 2064, on_cnt[2]);
    check_rng("ch3 on", 2, 16, on_cnt[3]);
    wait_sink(4'hf, 4'h0);
    check4("clk idle", 4'h1, {3'h0, inverted_clock_out});
    $display("test forward and pwm done");
  endtask
  task automatic test_freeze();
    clk_en <= 1'b0;
    current_select <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check4("frozen pins_en", 4'h1, current_resistor_pins_en);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check4("resumed pins_en", 4'hf, current_resistor_pins_en);
    current_select <= 1'b0;
    $display("test freeze done");
  endtask
  initial begin
    test_reset();
    test_select();
    test_latch();
    test_thermal();
    test_forward_pwm();
    test_freeze();
    give_verdict();
  end
endmodule
